/* pkg/jbst_pkg.sv */
// Package for the boundary-scan test access port.
// Assumes a single core clock that oversamples the test clock pin.
package jbst_pkg;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam int          IR_W        = 3;
    localparam logic [2:0]  INS_EXTEST  = 3'h0;
    localparam logic [2:0]  INS_SAMPLE  = 3'h4;
    localparam logic [2:0]  INS_IDCODE  = 3'h6;
    localparam logic [2:0]  INS_BYPASS  = 3'h7;
    // Pattern loaded into the instruction shifter at Capture-IR.
    localparam logic [2:0]  IR_CAPTURE  = 3'h1;

    // ------------------------------------------------------------------
    // Identification word layout
    // ------------------------------------------------------------------
    localparam int          ID_W        = 32;
    localparam int          PROD_LSB    = 1;
    localparam int          PROD_W      = 11;
    localparam int          PART_LSB    = 12;
    localparam int          PART_W      = 16;
    localparam int          REV_LSB     = 28;
    localparam int          REV_W       = 4;
    localparam logic        ID_MARKER   = 1'b1;

    // ------------------------------------------------------------------
    // Chain and reset timing
    // ------------------------------------------------------------------
    localparam int          BSC_LEN     = 98;
    localparam int          TLR_HIGHS   = 5;

    // ------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } jbst_state_t;

endpackage

/* rtl/jbst_sync.sv */
// Two-flop synchroniser for pins arriving from outside the clock domain.
// Assumes the destination clock is core_clk_i; no logic reads stage one.
`timescale 1ns/100ps
module jbst_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,   // Core clock.
    input  wire logic         resetn_i,     // Asynchronous reset, low.
    input  wire logic         en_i,         // Clock enable.
    input  wire logic [W-1:0] d_i,          // Asynchronous inputs.
    output logic      [W-1:0] q_o           // Synchronised outputs.
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // Next values hold while the enable is low.
    always_comb begin
        next_meta = en_i ? d_i  : meta;
        next_q    = en_i ? meta : q_o;
    end

    // Register both stages.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= next_meta;
            q_o  <= next_q;
        end
    end

endmodule // jbst_sync

/* rtl/jbst_tap.sv */
// Boundary-scan test access port: controller, instruction and data regs.
// Assumes test clock, mode, data and pin inputs are asynchronous pins;
// the core clock runs several times faster than the test clock.
//
// Functional notes
// - Three-bit instruction, shifted in LSB first.
// - Code 000: chain drives pins, captures inputs.
// - Code 100: chain samples, core path kept.
// - Code 110: identification word on serial path.
// - Code 111: bypass, one test clock delay.
// - Identification word leaves LSB first.
// - Identification word: marker, producer, part, revision.
// - Bypass is a single-bit serial path.
// - Chain is 98 bits, used by two instructions.
// - Sixteen-state controller with data and instruction branches.
// - Serial data moves at the test clock rate.
// - Five mode-high rising edges reach Test-Logic-Reset.
// - Test-Logic-Reset loads identification instruction.
// - Parallel chain output updates on falling edge only.
// - Controller starts in Test-Logic-Reset at reset.
`timescale 1ns/100ps
module jbst_tap
    import jbst_pkg::*;
#(
    parameter int                       CHAIN_LEN = jbst_pkg::BSC_LEN,
    parameter logic [jbst_pkg::PROD_W-1:0] PRODUCER = 11'h001, // Arbitrary.
    parameter logic [jbst_pkg::PART_W-1:0] PART_NUM = 16'h0001, // Arbitrary.
    parameter logic [jbst_pkg::REV_W-1:0]  REVISION = 4'h0      // Arbitrary.
) (
    input  wire logic                 core_clk_i,   // Core clock.
    input  wire logic                 resetn_i,     // Async reset, low.
    input  wire logic                 clk_en_i,     // Freezes state if low.
    input  wire logic                 tck_i,        // Test clock pin.
    input  wire logic                 tms_i,        // Test mode select pin.
    input  wire logic                 tdi_i,        // Test data in pin.
    output logic                      tdo_o,        // Test data out.
    output logic                      tdo_oe_o,     // Data out enable.
    input  wire logic [CHAIN_LEN-1:0] pin_in_i,     // Pin levels to capture.
    input  wire logic [CHAIN_LEN-1:0] core_out_i,   // Core values for pins.
    output logic      [CHAIN_LEN-1:0] pin_out_o,    // Values at the pins.
    output logic                      test_mode_o,  // Pins under test.
    output logic [jbst_pkg::IR_W-1:0] instr_o,      // Current instruction.
    output logic                      tlr_o         // In Test-Logic-Reset.
);
    import jbst_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    logic [2:0]           sync_q;
    logic [CHAIN_LEN-1:0] pin_sync;
    logic                 tck_s;
    logic                 tms_s;
    logic                 tdi_s;
    logic                 tck_d;
    logic                 rise;
    logic                 fall;

    // Test pins pass two flip-flops before any logic reads them.
    jbst_sync #(.W(3)) u_sync_tap (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .en_i       (clk_en_i),
        .d_i        ({tck_i, tms_i, tdi_i}),
        .q_o        (sync_q)
    );

    // Pin inputs to the chain are synchronised as well.
    jbst_sync #(.W(CHAIN_LEN)) u_sync_pins (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .en_i       (clk_en_i),
        .d_i        (pin_in_i),
        .q_o        (pin_sync)
    );

    assign tck_s = sync_q[2];
    assign tms_s = sync_q[1];
    assign tdi_s = sync_q[0];
    // Edges of the test clock set the serial rate.
    assign rise  = tck_s & ~tck_d;
    assign fall  = ~tck_s & tck_d;

    // ------------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_CHAIN, SEL_ID, SEL_BYP
    } jbst_sel_t;

    // Maps an instruction to the data register on the serial path.
    function automatic jbst_sel_t jbst_decode(input logic [2:0] ins);
        case (ins)
            INS_EXTEST: jbst_decode = SEL_CHAIN;
            INS_SAMPLE: jbst_decode = SEL_CHAIN;
            INS_IDCODE: jbst_decode = SEL_ID;
            INS_BYPASS: jbst_decode = SEL_BYP;
            default:    jbst_decode = SEL_BYP;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    jbst_state_t          state;
    jbst_state_t          next_state;
    logic [IR_W-1:0]      ir_sh;
    logic [IR_W-1:0]      next_ir_sh;
    logic [IR_W-1:0]      ir;
    logic [IR_W-1:0]      next_ir;
    logic [ID_W-1:0]      id_sh;
    logic [ID_W-1:0]      next_id_sh;
    logic                 byp;
    logic                 next_byp;
    logic [CHAIN_LEN-1:0] bsc;
    logic [CHAIN_LEN-1:0] next_bsc;
    logic [CHAIN_LEN-1:0] bsc_upd;
    logic [CHAIN_LEN-1:0] next_bsc_upd;
    logic                 next_tdo;
    logic                 next_tdo_oe;
    logic                 next_tck_d;
    logic [ID_W-1:0]      id_word;
    jbst_sel_t            sel;

    // Identification word built from its fields.
    assign id_word = {REVISION, PART_NUM, PRODUCER, ID_MARKER};
    assign sel     = jbst_decode(ir);

    // Controller transitions on each rising test clock edge.
    // The tester presents mode levels per edge.
    always_comb begin
        next_state = state;
        if (rise) begin
            case (state)
                ST_TLR:    next_state = tms_s ? ST_TLR    : ST_RTI;
                ST_RTI:    next_state = tms_s ? ST_SEL_DR : ST_RTI;
                ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR:  next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: next_state = tms_s ? ST_UPD_DR : ST_PAU_DR;
                ST_PAU_DR: next_state = tms_s ? ST_EX2_DR : ST_PAU_DR;
                ST_EX2_DR: next_state = tms_s ? ST_UPD_DR : ST_SH_DR;
                ST_UPD_DR: next_state = tms_s ? ST_SEL_DR : ST_RTI;
                // Mode high from Select-IR completes the five-edge path.
                ST_SEL_IR: next_state = tms_s ? ST_TLR    : ST_CAP_IR;
                ST_CAP_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR:  next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: next_state = tms_s ? ST_UPD_IR : ST_PAU_IR;
                ST_PAU_IR: next_state = tms_s ? ST_EX2_IR : ST_PAU_IR;
                ST_EX2_IR: next_state = tms_s ? ST_UPD_IR : ST_SH_IR;
                ST_UPD_IR: next_state = tms_s ? ST_SEL_DR : ST_RTI;
                default:   next_state = ST_TLR;
            endcase
        end
    end

    // Instruction shifter and current instruction.
    always_comb begin
        next_ir_sh = ir_sh;
        next_ir    = ir;
        if (state == ST_TLR) begin
            next_ir = INS_IDCODE;
        end
        if (rise) begin
            case (state)
                ST_CAP_IR: next_ir_sh = IR_CAPTURE;
                // New bits enter at the top so the first lands in bit 0.
                ST_SH_IR:  next_ir_sh = {tdi_s, ir_sh[IR_W-1:1]};
                default:   next_ir_sh = ir_sh;
            endcase
        end
        if (fall && state == ST_UPD_IR) begin
            next_ir = ir_sh;
        end
    end

    // Data registers: capture and shift on rising edges.
    always_comb begin
        next_id_sh = id_sh;
        next_byp   = byp;
        next_bsc   = bsc;
        if (rise && state == ST_CAP_DR) begin
            case (sel)
                SEL_ID:    next_id_sh = id_word;
                SEL_BYP:   next_byp   = 1'b0;
                SEL_CHAIN: begin
                    // Extest captures pin inputs; sample sees core too.
                    if (ir == INS_EXTEST) begin
                        next_bsc = pin_sync;
                    end else begin
                        next_bsc = pin_sync | core_out_i;
                    end
                end
                default:   next_byp   = 1'b0;
            endcase
        end
        if (rise && state == ST_SH_DR) begin
            case (sel)
                SEL_ID:    next_id_sh = {tdi_s, id_sh[ID_W-1:1]};
                SEL_BYP:   next_byp   = tdi_s;
                SEL_CHAIN: next_bsc   = {tdi_s, bsc[CHAIN_LEN-1:1]};
                default:   next_byp   = tdi_s;
            endcase
        end
    end

    // Parallel chain latch changes only in Update-DR, falling edge.
    always_comb begin
        next_bsc_upd = bsc_upd;
        if (fall && state == ST_UPD_DR && sel == SEL_CHAIN) begin
            next_bsc_upd = bsc;
        end
    end

    // Serial output changes on falling edges, driven only while shifting.
    always_comb begin
        next_tdo    = tdo_o;
        next_tdo_oe = tdo_oe_o;
        next_tck_d  = tck_s;
        if (fall) begin
            next_tdo_oe = (state == ST_SH_DR) || (state == ST_SH_IR);
            if (state == ST_SH_IR) begin
                next_tdo = ir_sh[0];
            end else begin
                case (sel)
                    SEL_ID:    next_tdo = id_sh[0];
                    SEL_CHAIN: next_tdo = bsc[0];
                    default:   next_tdo = byp;
                endcase
            end
        end
    end

    // Register all state; the enable freezes everything.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state    <= ST_TLR;
            ir_sh    <= IR_CAPTURE;
            ir       <= INS_IDCODE;
            id_sh    <= '0;
            byp      <= 1'b0;
            bsc      <= '0;
            bsc_upd  <= '0;
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
            tck_d    <= 1'b0;
        end else if (clk_en_i) begin
            state    <= next_state;
            ir_sh    <= next_ir_sh;
            ir       <= next_ir;
            id_sh    <= next_id_sh;
            byp      <= next_byp;
            bsc      <= next_bsc;
            bsc_upd  <= next_bsc_upd;
            tdo_o    <= next_tdo;
            tdo_oe_o <= next_tdo_oe;
            tck_d    <= next_tck_d;
        end
    end

    // Pins follow the latch under extest, the core otherwise.
    always_comb begin
        test_mode_o = (ir == INS_EXTEST);
        pin_out_o   = test_mode_o ? bsc_upd : core_out_i;
        instr_o     = ir;
        tlr_o       = (state == ST_TLR);
    end

endmodule // jbst_tap

/* testbench/jbst_tap_assertions.sv */
// Checker on the pins of the test access port, attached by bind.
// Assumes eight core clocks for each test clock period.
`timescale 1ns/100ps
module jbst_tap_assertions
    import jbst_pkg::*;
#(
    parameter int CHAIN_LEN = 98
) (
    input  wire logic                 core_clk_i,  // Core clock.
    input  wire logic                 resetn_i,    // Reset, low.
    input  wire logic                 clk_en_i,    // Run enable.
    input  wire logic                 tck_i,       // Test clock.
    input  wire logic                 tms_i,       // Mode select.
    input  wire logic                 tdi_i,       // Data in.
    input  wire logic                 tdo_o,       // Data out.
    input  wire logic                 tdo_oe_o,    // Out enable.
    input  wire logic [CHAIN_LEN-1:0] pin_in_i,    // Pin levels.
    input  wire logic [CHAIN_LEN-1:0] core_out_i,  // Core values.
    input  wire logic [CHAIN_LEN-1:0] pin_out_o,   // Pin values.
    input  wire logic                 test_mode_o, // Pins under test.
    input  wire logic [2:0]           instr_o,     // Instruction.
    input  wire logic                 tlr_o        // Reset state.
);
    logic       tck_q;
    logic [3:0] fall_age;
    logic [2:0] high_cnt;
    logic       next_tck_q;
    logic [3:0] next_fall_age;
    logic [2:0] next_high_cnt;

    // Cycles since the last test clock fall, and mode-high rise run.
    always_comb begin
        next_tck_q    = tck_i;
        next_fall_age = fall_age + {3'h0, fall_age != 4'hf};
        next_high_cnt = high_cnt;
        if (tck_q && !tck_i) begin
            next_fall_age = 4'h0;
        end
        if (!tck_q && tck_i) begin
            next_high_cnt = tms_i ? high_cnt + {2'h0, high_cnt != 3'h7} : 3'h0;
        end
    end

    // Registers the helper state.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tck_q    <= 1'b0;
            fall_age <= 4'hf;
            high_cnt <= 3'h0;
        end else begin
            tck_q    <= next_tck_q;
            fall_age <= next_fall_age;
            high_cnt <= next_high_cnt;
        end
    end

    // -------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    a_tdo_on_fall:
        assert property ($changed(tdo_o) |-> fall_age <= 4'h5)
        else $error("Data out moved away from a clock fall.");
    a_oe_on_fall:
        assert property ($changed(tdo_oe_o) |-> fall_age <= 4'h5)
        else $error("Out enable moved away from a clock fall.");
    a_oe_holds:
        assert property ($rose(tdo_oe_o) |-> tdo_oe_o [*6])
        else $error("Out enable dropped within a clock period.");
    a_latch_hold:
        assert property (test_mode_o && $past(test_mode_o)
            && $changed(pin_out_o) |-> fall_age <= 4'h5)
        else $error("Pin latch moved away from a clock fall.");
    a_mode_code:
        assert property (test_mode_o == (instr_o == INS_EXTEST))
        else $error("Test mode does not follow the instruction.");
    a_core_path:
        assert property (!test_mode_o |-> pin_out_o == core_out_i)
        else $error("Pins left the core path outside test.");
    a_five_highs:
        assert property (high_cnt >= 3'h5 |-> ##[0:6] tlr_o)
        else $error("Five mode-high rises did not reach reset state.");
    a_tlr_ident:
        assert property (tlr_o && clk_en_i |=> instr_o == INS_IDCODE)
        else $error("Reset state did not load identification.");
    a_tlr_quiet:
        assert property (tlr_o |-> !tdo_oe_o)
        else $error("Data out driven in reset state.");

    c_shift_run: cover property (tdo_oe_o [*8]);
    c_pins_load: cover property (test_mode_o && $changed(pin_out_o));
    c_tlr_enter: cover property ($rose(tlr_o));
endmodule // jbst_tap_assertions

/* testbench/jbst_tester.sv */
// Model of the external test controller.
// Assumes its tasks are called just after a core clock edge.
`timescale 1ns/100ps
module jbst_tester (
    input  wire logic core_clk_i, // Pacing clock.
    input  wire logic tdo_i,      // Device data out.
    input  wire logic tdo_oe_i,   // Device out enable.
    output logic      tck_o,      // Test clock, still between frames.
    output logic      tms_o,      // Mode select.
    output logic      tdi_o       // Serial data in.
);
    // Idle levels: clock low, mode high.
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One test clock period of eight core clocks; mode and data change
    // with the fall and hold across the rise, data out is read last.
    task automatic step(input logic m, input logic d,
                        output logic q, output logic e);
        tck_o <= 1'b0;
        tms_o <= m;
        tdi_o <= d;
        repeat (4) @(posedge core_clk_i);
        tck_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        q = tdo_i;
        e = tdo_oe_i;
    endtask

    // A move without data: the data line flips so no stale bit passes.
    task automatic go(input logic m);
        logic q;
        logic e;
        step(m, ~tdi_o, q, e);
    endtask
endmodule // jbst_tester

/* testbench/jbst_tap_test.sv */
// Self-checking bench for the test access port with a tester model.
// Assumes the package, the port, the tester and the checker are built.
`timescale 1ns/100ps
module jbst_tap_test;
    import jbst_pkg::*;
    localparam int                N    = BSC_LEN;
    localparam logic [PROD_W-1:0] PROD = 11'h2b5;  // Arbitrary.
    localparam logic [PART_W-1:0] PART = 16'h3c1e; // Arbitrary.
    localparam logic [REV_W-1:0]  REV  = 4'h9;     // Arbitrary.
    localparam logic [127:0]      MASK = (128'h1 << N) - 128'h1;

    logic         core_clk_i;
    logic         resetn_i   = 1'b0;
    logic         clk_en_i   = 1'b1;
    logic         tck_i;
    logic         tms_i;
    logic         tdi_i;
    logic         tdo_o;
    logic         tdo_oe_o;
    logic [N-1:0] pin_in_i   = '0;
    logic [N-1:0] core_out_i = '0;
    logic [N-1:0] pin_out_o;
    logic         test_mode_o;
    logic [2:0]   instr_o;
    logic         tlr_o;
    int           err_count   = 0;
    int           check_count = 0;
    int           cycles      = 0;
    int           seed        = 32'h68e1;
    logic [2:0]   codes[$] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3, 3'h5};

    jbst_tap #(.PRODUCER(PROD), .PART_NUM(PART), .REVISION(REV))
    jbst_tap_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .clk_en_i(clk_en_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
        .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_in_i(pin_in_i),
        .core_out_i(core_out_i), .pin_out_o(pin_out_o),
        .test_mode_o(test_mode_o), .instr_o(instr_o), .tlr_o(tlr_o));

    jbst_tester jbst_tester_inst (.core_clk_i(core_clk_i), .tdo_i(tdo_o),
        .tdo_oe_i(tdo_oe_o), .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i));

    // Core clock and hang limit.
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles++;
        // Brief one-cycle stalls check that the enable freezes all state.
        clk_en_i <= (cycles % 13) != 0;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end

    // Counts, verdict and end of run.
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [127:0] x, y);
        check_count++;
        if (y !== x) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, x, y);
        end
    endtask

    function automatic logic [127:0] rnd();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    // Walks the controller with a list of mode levels, first in bit 0.
    task automatic moves(input logic [7:0] m, input int n);
        for (int i = 0; i < n; i++)
            jbst_tester_inst.go(m[i]);
    endtask

    // Scan from idle through the data or instruction branch and back.
    task automatic scan(input logic ir, input int n, input logic [127:0] d,
                        output logic [127:0] q);
        logic e;
        logic oe;
        q = '0;
        oe = 1'b1;
        moves(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            jbst_tester_inst.step(i == n - 1, d[i], q[i], e);
            oe = oe & e;
        end
        moves(8'h01, 2);
        chk("shift oe", 128'h1, 128'(oe));
        chk("idle oe", 128'h0, 128'(tdo_oe_o));
    endtask

    // Main sequence: every code, then the mode-high escape.
    initial begin
        logic [127:0] a, b, p, q, x;
        logic [2:0]   c;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        chk("tlr", 128'h1, 128'(tlr_o));
        chk("instr", 128'(INS_IDCODE), 128'(instr_o));
        moves(8'h00, 1);
        foreach (codes[k]) begin
            c = codes[k];
            scan(1'b1, IR_W, 128'(c), q);
            chk("ir capture", 128'(IR_CAPTURE), q);
            chk("instr", 128'(c), 128'(instr_o));
            p = rnd();
            if (c == INS_EXTEST || c == INS_SAMPLE) begin
                a = rnd() & MASK;
                b = rnd() & MASK;
                p = p & MASK;
                pin_in_i   <= a[N-1:0];
                core_out_i <= b[N-1:0];
                scan(1'b0, N, p, q);
                x = (c == INS_EXTEST) ? a : a | b;
                chk("capture", x, q);
                x = (c == INS_EXTEST) ? p : b;
                chk("pins", x, 128'(pin_out_o));
            end else if (c == INS_IDCODE) begin
                scan(1'b0, ID_W, p, q);
                x = 128'({REV, PART, PROD, ID_MARKER});
                chk("idcode", x, q);
            end else begin
                scan(1'b0, 8, p, q);
                chk("bypass", 128'({p[6:0], 1'b0}), q);
            end
            $display("Instruction %b done", c);
        end
        // Into Shift-DR, then four mode-high rises stop short of reset.
        moves(8'h79, 7);
        chk("tlr early", 128'h0, 128'(tlr_o));
        moves(8'h03, 2);
        chk("tlr", 128'h1, 128'(tlr_o));
        chk("instr", 128'(INS_IDCODE), 128'(instr_o));
        $display("Mode-high escape done");
        test_done();
    end
endmodule // jbst_tap_test

bind jbst_tap jbst_tap_assertions #(.CHAIN_LEN(CHAIN_LEN)) chk_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
    .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o), .pin_in_i(pin_in_i), .core_out_i(core_out_i),
    .pin_out_o(pin_out_o), .test_mode_o(test_mode_o),
    .instr_o(instr_o), .tlr_o(tlr_o));
